// ==== src/asr_consts.svh ====
// asr_consts.svh: offsets, field positions, reset values and word/frame sizes
// for the receive slot-mapping slice; included by the slot-mapping module and the benches.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// register addresses on the control bus
`define ASR_ADDR_CH4 8'h2B
`define ASR_ADDR_CH5 8'h2C
`define ASR_ADDR_CH6 8'h2D

// reset values of the routing registers
`define ASR_RST_CH4 8'h03
`define ASR_RST_CH5 8'h04
`define ASR_RST_CH6 8'h05

// field positions
`define ASR_SLOT_LSB 0
`define ASR_SLOT_MSB 4
`define ASR_CH4_SEL_BIT 5
`define ASR_SEL_LSB 5
`define ASR_SEL_MSB 6

// slot-number values at or above this pick the right half of an i2s/lj frame
`define ASR_RIGHT_BASE 5'h10

// serial word and frame figures
`define ASR_WORD_BITS 32
`define ASR_FRAME_SLOTS 32

`endif

// ==== src/asr_pkg.sv ====
// asr_pkg.sv: types shared by the slot-mapping slice.
// assumes asr_consts.svh sits beside it on the include path.
package asr_pkg;
   // serial frame format chosen by the framing logic
   typedef enum logic [1:0] {
      ASR_FMT_TDM = 2'h0,
      ASR_FMT_I2S = 2'h1,
      ASR_FMT_LJ  = 2'h2
   } asr_fmt_t;

   // channel-5 / channel-6 source select codes
   typedef enum logic [1:0] {
      ASR_SRC_OFF  = 2'h0,
      ASR_SRC_DAC  = 2'h1,
      ASR_SRC_LOOP = 2'h2,
      ASR_SRC_RSVD = 2'h3
   } asr_src_t;

   // one captured sample tagged with its slot position
   typedef struct packed {
      logic [4:0] slot;
      logic [31:0] data;
   } asr_word_t;

   // one routed sample on the system side
   typedef struct packed {
      logic [1:0] chan;
      logic [31:0] data;
   } asr_out_t;
endpackage

// ==== src/asr_fifo.sv ====
// asr_fifo.sv: synchronous fifo with valid/ready on both sides.
// assumes both sides share clk_i; full and empty are exact.
`timescale 1ns/1ns
module asr_fifo #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // storage array
   logic [AW-1:0] wr_ptr;           // write slot
   logic [AW-1:0] rd_ptr;           // read slot
   logic [AW:0] count;              // words held
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   // ----------------------------------------
   // pointer and count update
   // ----------------------------------------
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage has no reset; only valid words are ever read out
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
endmodule

// ==== src/asr_cdc.sv ====
// asr_cdc.sv: carries one word from the link domain to the system domain
// by a toggle handshake; the source holds the word until acknowledged.
// assumes the link clock runs while a handoff is open.
`timescale 1ns/1ns
module asr_cdc #(
   parameter int WIDTH = 37
) (
   input wire logic lclk_i,
   input wire logic lrst_i,
   input wire logic [WIDTH-1:0] src_data_i,
   input wire logic src_valid_i,
   output logic src_ready_o,
   input wire logic clk_i,
   input wire logic srst_i,
   output logic [WIDTH-1:0] dst_data_o,
   output logic dst_valid_o
);
   logic req_tgl;             // link side request toggle
   logic [WIDTH-1:0] hold;    // word held stable during handoff
   logic ack_s1;              // ack sync stage 1
   logic ack_s2;              // ack sync stage 2
   logic req_s1;              // req sync stage 1
   logic req_s2;              // req sync stage 2
   logic req_s3;              // last seen request
   logic [WIDTH-1:0] dst_data;
   logic dst_valid;
   logic next_req_tgl;
   logic [WIDTH-1:0] next_hold;
   logic take;

   // ----------------------------------------
   // link side: launch a word when idle
   // ----------------------------------------
   always_comb begin
      src_ready_o = (req_tgl == ack_s2);
      take = src_valid_i && src_ready_o;
      next_req_tgl = take ? ~req_tgl : req_tgl;
      next_hold = take ? src_data_i : hold;
   end

   always_ff @(posedge lclk_i) begin
      if (lrst_i) begin
         req_tgl <= 1'b0;
         hold <= '0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         req_tgl <= next_req_tgl;
         hold <= next_hold;
         ack_s1 <= req_s3;
         ack_s2 <= ack_s1;
      end
   end

   // ----------------------------------------
   // system side: new toggle means a new word
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         dst_data <= '0;
         dst_valid <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         dst_valid <= (req_s2 != req_s3);
         dst_data <= (req_s2 != req_s3) ? hold : dst_data;
      end
   end

   assign dst_data_o = dst_data;
   assign dst_valid_o = dst_valid;
endmodule

// ==== src/asr_rx_slot_map.sv ====
// asr_rx_slot_map.sv: receive slot mapping for serial input channels 4-6.
// assumes the framing logic elsewhere delivers each slot word on the link
// clock with its slot index; the host writes the registers over the
// documented control port, one byte per access.
// the format input is retimed into the link domain; words that
// match no enabled channel are dropped silently.
`timescale 1ns/1ns
`include "asr_consts.svh"

// Overview of operation
// - ch4 bit5: 0 off, 1 dac ch4
// - tdm: channel takes slot equal to index
// - i2s/lj: 0-15 left, 16-31 right slots
// - ch4 slot index resets to three
// - ch5 bits6-5: off, dac, loopback, reserved
// - ch5 slot index resets to four
// - reserved upper bits read zero
// - ch5 register at 0x2C, reset 0x04
// - ch6 register at 0x2D, reset 0x05
// - ch4 register at 0x2B, reset 0x03
module asr_rx_slot_map
   import asr_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // system clock for registers, matching and output
   input wire logic clk_i,
   // synchronous reset back to the register reset values
   input wire logic srst_i,
   // control port, system clock
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // hit marks a read of a mapped register
   output logic reg_hit_o,
   // frame format, quasi-static
   input wire asr_fmt_t fmt_i,
   // link side, its own clock
   input wire logic lclk_i,
   input wire logic lrst_i,
   // raise lrst_i together with srst_i
   input wire logic [`ASR_WORD_BITS-1:0] slot_data_i,
   // index within the frame, plus the right-half flag
   input wire logic [4:0] slot_idx_i,
   input wire logic slot_right_i,
   // valid/ready handshake with the framer
   input wire logic slot_valid_i,
   output logic slot_ready_o,
   // routed samples toward the datapath
   output asr_out_t out_word_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   // loopback request of channel 5
   output logic loop_sel_o
);
   // width of one tagged word in the crossing and fifo
   localparam int WW = $bits(asr_word_t);

   // ----------------------------------------
   // state and wiring
   // ----------------------------------------
   // routing registers hold defined bits only
   logic [7:0] ch4_reg;              // channel-4 routing
   logic [7:0] ch5_reg;              // channel-5 routing
   logic [7:0] ch6_reg;              // channel-6 routing
   logic [7:0] next_ch4_reg;
   logic [7:0] next_ch5_reg;
   logic [7:0] next_ch6_reg;
   // read side of the control port
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic hit;
   logic next_hit;
   // link-side view and the crossing
   asr_fmt_t fmt_q;                  // format held in the link-side view
   asr_word_t cap_word;              // link-side tagged word
   asr_word_t sys_word;              // word after crossing
   logic sys_valid;
   // buffer and output stage
   asr_word_t fifo_word;
   logic fifo_valid;
   logic fifo_ready;
   asr_out_t out_word;
   logic out_valid;
   asr_out_t next_out_word;
   logic next_out_valid;
   // result of the slot comparison
   logic [1:0] match_chan;
   logic match_any;

   // ----------------------------------------
   // slot position helper
   // ----------------------------------------
   // turns a frame position into the slot-number code; right halves of an
   // i2s/lj frame start at 16, tdm uses the index directly
   function automatic logic [4:0] slot_code(input asr_fmt_t fmt, input logic [4:0] idx, input logic right);
      logic [4:0] code;
      // start from the tdm reading of the index
      code = idx;
      if (fmt != ASR_FMT_TDM) begin
         // left halves keep the low four index bits
         code = {right, idx[3:0]} | (right ? `ASR_RIGHT_BASE : 5'h00);
      end
      // tdm codes 16-31 are plain slots
      return code;
   endfunction

   // read-back masks: reserved bits come back as zero whatever was written
   // (writes pass through the same masks)
   function automatic logic [7:0] ch4_view(input logic [7:0] r);
      return {2'h0, r[5:0]};
   endfunction

   // channels 5 and 6 have one reserved bit, channel 4 two
   function automatic logic [7:0] ch56_view(input logic [7:0] r);
      return {1'h0, r[6:0]};
   endfunction

   // ----------------------------------------
   // register file
   // ----------------------------------------
   // writes store only defined bits so a stray reserved write never sticks
   always_comb begin
      // by default every register except hit keeps its value; hit defaults low
      next_ch4_reg = ch4_reg;
      next_ch5_reg = ch5_reg;
      next_ch6_reg = ch6_reg;
      next_rdata = rdata;
      next_hit = 1'b0;
      // a write lands at the edge that samples the strobe
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `ASR_ADDR_CH4: next_ch4_reg = ch4_view(reg_wdata_i);
            `ASR_ADDR_CH5: next_ch5_reg = ch56_view(reg_wdata_i);
            `ASR_ADDR_CH6: next_ch6_reg = ch56_view(reg_wdata_i);
            // other addresses belong to other slices
            default: ;
         endcase
      end
      // a read returns the value held before this edge
      if (reg_rd_i) begin
         // a mapped read raises hit for one cycle
         next_hit = 1'b1;
         unique case (reg_addr_i)
            `ASR_ADDR_CH4: next_rdata = ch4_view(ch4_reg);
            `ASR_ADDR_CH5: next_rdata = ch56_view(ch5_reg);
            `ASR_ADDR_CH6: next_rdata = ch56_view(ch6_reg);
            default: begin
               // unmapped reads answer zero and drop the hit flag
               next_rdata = 8'h00;
               next_hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ch4_reg <= `ASR_RST_CH4;
         ch5_reg <= `ASR_RST_CH5;
         ch6_reg <= `ASR_RST_CH6;
         // read port idles at zero with hit low
         rdata <= 8'h00;
         hit <= 1'b0;
      end else begin
         // registers follow the decoded next values
         ch4_reg <= next_ch4_reg;
         ch5_reg <= next_ch5_reg;
         ch6_reg <= next_ch6_reg;
         rdata <= next_rdata;
         hit <= next_hit;
      end
   end

   // read data holds until the next read; hit lasts one cycle
   assign reg_rdata_o = rdata;
   assign reg_hit_o = hit;

   // ----------------------------------------
   // link side capture
   // ----------------------------------------
   // format is a quasi-static setting; two flops bring it to the link
   // clock, and it should only change while the link is idle
   // first stage is read only by the second stage
   asr_fmt_t fmt_s1;

   // both stages reset to tdm
   always_ff @(posedge lclk_i) begin
      if (lrst_i) begin
         fmt_s1 <= ASR_FMT_TDM;
         fmt_q <= ASR_FMT_TDM;
      end else begin
         fmt_s1 <= fmt_i;
         fmt_q <= fmt_s1;
      end
   end

   // the code is formed before the crossing, so the system side
   // compares it directly with the slot fields
   always_comb begin
      cap_word.slot = slot_code(fmt_q, slot_idx_i, slot_right_i);
      cap_word.data = slot_data_i;
   end

   // every slot word crosses; channel match happens on the system side so
   // register values never need to cross into the link domain
   // the framer is held off by ready until the word is taken
   asr_cdc #(
      .WIDTH(WW)
   ) u_cdc (
      .lclk_i(lclk_i),
      .lrst_i(lrst_i),
      .src_data_i(cap_word),
      .src_valid_i(slot_valid_i),
      .src_ready_o(slot_ready_o),
      .clk_i(clk_i),
      .srst_i(srst_i),
      .dst_data_o(sys_word),
      .dst_valid_o(sys_valid)
   );

   // ----------------------------------------
   // slot match against routing registers
   // ----------------------------------------
   // ch4 checked first; two channels on the same slot deliver only the lower
   // a ch5/ch6 source other than dac never claims a slot;
   // ch5 loopback goes out on loop_sel_o instead; ch6 loopback drives nothing
   always_comb begin
      // by default no channel claims the word
      match_chan = 2'h0;
      match_any = 1'b0;
      if (ch4_reg[`ASR_CH4_SEL_BIT] && sys_word.slot == ch4_reg[`ASR_SLOT_MSB:`ASR_SLOT_LSB]) begin
         match_chan = 2'h0;
         match_any = 1'b1;
      end else if (asr_src_t'(ch5_reg[`ASR_SEL_MSB:`ASR_SEL_LSB]) == ASR_SRC_DAC
                   && sys_word.slot == ch5_reg[`ASR_SLOT_MSB:`ASR_SLOT_LSB]) begin
         match_chan = 2'h1;
         match_any = 1'b1;
      end else if (asr_src_t'(ch6_reg[`ASR_SEL_MSB:`ASR_SEL_LSB]) == ASR_SRC_DAC
                   && sys_word.slot == ch6_reg[`ASR_SLOT_MSB:`ASR_SLOT_LSB]) begin
         match_chan = 2'h2;
         match_any = 1'b1;
      end
   end

   // a matched sample is dropped if the fifo is full: the serial stream
   // cannot be paused, so losing a word beats stalling the whole frame
   // a refused push simply drops the word, so the full flag
   // needs no reader here
   asr_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .in_data_i({match_chan, 3'h0, sys_word.data}),
      .in_valid_i(sys_valid && match_any),
      .in_ready_o(),
      .out_data_o(fifo_word),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready)
   );

   // ----------------------------------------
   // output register
   // ----------------------------------------
   // one stage so both outputs come from flops
   always_comb begin
      // take a word when the stage is empty or draining
      fifo_ready = !out_valid || out_ready_i;
      // hold the word unless a new one is taken
      next_out_word = out_word;
      next_out_valid = out_valid;
      if (fifo_ready) begin
         next_out_valid = fifo_valid;
         // an empty fifo leaves the stage empty
         if (fifo_valid) begin
            next_out_word.chan = fifo_word.slot[4:3];
            next_out_word.data = fifo_word.data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         // fifo pointers clear on the same reset
         out_word <= '0;
         out_valid <= 1'b0;
      end else begin
         out_word <= next_out_word;
         out_valid <= next_out_valid;
      end
   end

   // outputs are the registered stage itself
   assign out_word_o = out_word;
   assign out_valid_o = out_valid;
   // loopback request for channel 5: feeds the adc-to-serial path elsewhere
   // a reserved code neither routes nor loops back
   assign loop_sel_o = (asr_src_t'(ch5_reg[`ASR_SEL_MSB:`ASR_SEL_LSB]) == ASR_SRC_LOOP);
endmodule

// ==== tb/asr_properties.sv ====
// asr_properties.sv: port-level checks for the receive slot-mapping slice.
// assumes it is bound to asr_rx_slot_map and sees only its system ports.
`timescale 1ns/1ns
`include "asr_consts.svh"
module asr_rx_props
   import asr_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_hit_o,
   input wire asr_out_t out_word_o,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic loop_sel_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // ------------------------------------------------
   // helper state
   // ------------------------------------------------
   logic map_hit; // address is one of the three routing registers
   logic [2:0] seen; // register written since reset, so no reset value
   logic [2:0] next_seen;
   assign map_hit = reg_addr_i inside {`ASR_ADDR_CH4, `ASR_ADDR_CH5, `ASR_ADDR_CH6};
   // track writes so reset-value checks stop once a register is changed
   always_comb begin
      next_seen = seen;
      if (reg_wr_i && map_hit) begin
         next_seen[2'(reg_addr_i - `ASR_ADDR_CH4)] = 1'b1;
      end
      if (srst_i) begin
         next_seen = 3'h0;
      end
   end
   always_ff @(posedge clk_i) begin
      seen <= next_seen;
   end
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   AST_HIT_MAPPED: assert property (reg_rd_i && map_hit |=> reg_hit_o)
      else $error("mapped read without hit");
   AST_UNMAPPED: assert property (reg_rd_i && !map_hit |=> !reg_hit_o && reg_rdata_o == 8'h00)
      else $error("unmapped read not empty");
   AST_CH4_RSV: assert property (reg_rd_i && reg_addr_i == `ASR_ADDR_CH4 |=> reg_rdata_o[7:6] == 2'h0)
      else $error("ch4 reserved bits set");
   AST_CH56_RSV: assert property (reg_rd_i && reg_addr_i inside {`ASR_ADDR_CH5, `ASR_ADDR_CH6}
      |=> !reg_rdata_o[7])
      else $error("ch5/ch6 reserved bit set");
   AST_RST_CH4: assert property (reg_rd_i && reg_addr_i == `ASR_ADDR_CH4 && !seen[0] |=> reg_rdata_o == 8'h03)
      else $error("ch4 reset value wrong");
   AST_RST_CH5: assert property (reg_rd_i && reg_addr_i == `ASR_ADDR_CH5 && !seen[1] |=> reg_rdata_o == 8'h04)
      else $error("ch5 reset value wrong");
   AST_RST_CH6: assert property (reg_rd_i && reg_addr_i == `ASR_ADDR_CH6 && !seen[2] |=> reg_rdata_o == 8'h05)
      else $error("ch6 reset value wrong");
   AST_WR_RD: assert property (reg_wr_i && reg_addr_i == `ASR_ADDR_CH5 ##1 !reg_wr_i ##1 reg_rd_i &&
      reg_addr_i == `ASR_ADDR_CH5 |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h7F))
      else $error("ch5 readback differs from write");
   AST_LOOP_SEL: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == `ASR_ADDR_CH5
      |=> loop_sel_o == (reg_rdata_o[6:5] == 2'h2))
      else $error("loopback select disagrees with field");
   // a stalled output must not change under the sink
   AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_word_o))
      else $error("output changed while stalled");
   cover property (reg_rd_i && map_hit);
   cover property (out_valid_o && out_ready_i && out_word_o.chan == 2'h1);
   cover property (loop_sel_o);
endmodule

// ==== tb/asr_link_host.sv ====
// asr_link_host.sv: far-side framer model feeding slot words to the link.
// assumes the bench gates its clock with run_i.
`timescale 1ns/1ns
module asr_link_host
   import asr_pkg::*;
(
   input wire logic run_i,
   output logic lclk_o,
   input wire logic slot_ready_i,
   output asr_word_t word_o,
   output logic right_o,
   output logic valid_o
);
   // 30 ns link clock, offset so no edge meets a system edge
   initial begin
      lclk_o = 1'b0;
      word_o = '0;
      right_o = 1'b0;
      valid_o = 1'b0;
      #4;
      forever #15 lclk_o = run_i & ~lclk_o;
   end
   // hold the word until ready is seen at a rising link edge
   task automatic send(input logic [4:0] idx, input logic rt, input logic [31:0] d);
      @(negedge lclk_o);
      word_o = '{slot: idx, data: d};
      right_o = rt;
      valid_o = 1'b1;
      while (slot_ready_i !== 1'b1) @(negedge lclk_o);
      @(posedge lclk_o);
      @(negedge lclk_o);
      // released lines show the inverse, never a stale copy
      word_o = ~word_o;
      right_o = ~rt;
      valid_o = 1'b0;
   endtask
endmodule

// ==== tb/asr_rx_slot_mapping_tb_top.sv ====
// asr_rx_slot_mapping_tb_top.sv: self-checking bench for the slot mapping.
// assumes asr_link_host and asr_rx_props are compiled before it.
`timescale 1ns/1ns
`include "asr_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("Error %0t: got %h exp %h", $time, g, e); end end
module asr_rx_slot_mapping_tb_top
   import asr_pkg::*;
;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic reg_hit_o;
   asr_fmt_t fmt_i = ASR_FMT_TDM;
   logic run = 1'b1; // link clock gate
   logic lclk, slot_ready, right, valid;
   asr_word_t lw; // slot word from the host model
   asr_out_t out_word_o;
   logic out_valid_o, loop_sel_o;
   logic out_ready_i = 1'b1;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   asr_out_t got[$]; // words accepted by the sink
   always #50 clk_i = ~clk_i;
   // both resets move together, as the design asks
   asr_rx_slot_map #(.FIFO_DEPTH(8)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .reg_hit_o(reg_hit_o), .fmt_i(fmt_i), .lclk_i(lclk), .lrst_i(srst_i), .slot_data_i(lw.data),
      .slot_idx_i(lw.slot), .slot_right_i(right), .slot_valid_i(valid), .slot_ready_o(slot_ready),
      .out_word_o(out_word_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .loop_sel_o(loop_sel_o));
   asr_link_host host_u (.run_i(run), .lclk_o(lclk), .slot_ready_i(slot_ready), .word_o(lw), .right_o(right),
      .valid_o(valid));
   // ------------------------------------------------
   // sink, bus tasks and verdict
   // ------------------------------------------------
   always @(posedge clk_i) begin
      if (out_valid_o === 1'b1 && out_ready_i) begin
         got.push_back(out_word_o);
      end
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         $display("Error %0t: timeout", $time);
         conclude();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      `CHK(reg_rdata_o, e)
      `CHK(reg_hit_o, h)
   endtask
   // bounded wait for one routed word
   task automatic expect_out(input logic [1:0] c, input logic [31:0] d);
      asr_out_t w;
      for (int n = 0; n < 40 && got.size() == 0; n++) @(negedge clk_i);
      w = (got.size() != 0) ? got.pop_front() : '0;
      `CHK(w, asr_out_t'{chan: c, data: d})
   endtask
   task automatic expect_none();
      repeat (30) @(negedge clk_i);
      `CHK(got.size(), 0)
   endtask
   task automatic set_fmt(input asr_fmt_t f);
      @(negedge clk_i);
      fmt_i = f;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic conclude();
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   initial begin
      repeat (6) @(negedge clk_i);
      srst_i = 1'b0;
      rdchk(`ASR_ADDR_CH4, 8'h03, 1'b1);
      rdchk(`ASR_ADDR_CH5, 8'h04, 1'b1);
      rdchk(`ASR_ADDR_CH6, 8'h05, 1'b1);
      rdchk(8'h2E, 8'h00, 1'b0);
      // enable each channel on its default slot
      wr(`ASR_ADDR_CH4, 8'h23);
      wr(`ASR_ADDR_CH5, 8'h24);
      wr(`ASR_ADDR_CH6, 8'h25);
      host_u.send(5'h03, 1'b0, 32'hA000_0003);
      expect_out(2'h0, 32'hA000_0003);
      host_u.send(5'h04, 1'b0, 32'hA000_0004);
      expect_out(2'h1, 32'hA000_0004);
      host_u.send(5'h05, 1'b0, 32'hA000_0005);
      expect_out(2'h2, 32'hA000_0005);
      host_u.send(5'h06, 1'b0, 32'hA000_0006);
      expect_none();
      // every channel-5 source code; only the dac code routes a word
      for (int c = 0; c < 4; c++) begin
         wr(`ASR_ADDR_CH5, {1'b0, 2'(c), 5'h04});
         rdchk(`ASR_ADDR_CH5, {1'b0, 2'(c), 5'h04}, 1'b1);
         `CHK(loop_sel_o, 1'(c == 2))
         host_u.send(5'h04, 1'b0, 32'hC0DE_0000 + 32'(c));
         if (c == 1) expect_out(2'h1, 32'hC0DE_0001);
         else expect_none();
      end
      // tdm edge slots, then channel 4 switched off
      wr(`ASR_ADDR_CH4, 8'h3F);
      host_u.send(5'h1F, 1'b0, 32'hB000_001F);
      expect_out(2'h0, 32'hB000_001F);
      wr(`ASR_ADDR_CH4, 8'h20);
      host_u.send(5'h00, 1'b0, 32'hB000_0000);
      expect_out(2'h0, 32'hB000_0000);
      wr(`ASR_ADDR_CH4, 8'h00);
      host_u.send(5'h00, 1'b0, 32'hB000_0100);
      expect_none();
      // i2s: code 21 is right slot 5, left slot 5 stays with channel 6
      set_fmt(ASR_FMT_I2S);
      wr(`ASR_ADDR_CH4, 8'h35);
      host_u.send(5'h05, 1'b1, 32'hD000_0015);
      expect_out(2'h0, 32'hD000_0015);
      host_u.send(5'h05, 1'b0, 32'hD000_0005);
      expect_out(2'h2, 32'hD000_0005);
      // lj: code 15 is left slot 15, right slot 15 unclaimed
      set_fmt(ASR_FMT_LJ);
      wr(`ASR_ADDR_CH4, 8'h2F);
      host_u.send(5'h0F, 1'b1, 32'hD000_001F);
      expect_none();
      // sink stalls while eight words queue (one in the output stage, seven in the fifo), then drains in order
      @(negedge clk_i);
      out_ready_i = 1'b0;
      for (int i = 0; i < 8; i++) host_u.send(5'h0F, 1'b0, 32'hE000_0000 + 32'(i));
      repeat (20) @(negedge clk_i);
      out_ready_i = 1'b1;
      for (int i = 0; i < 8; i++) expect_out(2'h0, 32'hE000_0000 + 32'(i));
      // all defined bits set; reserved bits are written as zero and read zero
      for (int i = 0; i < 3; i++) begin
         wr(`ASR_ADDR_CH4 + 8'(i), (i == 0) ? 8'h3F : 8'h7F);
         rdchk(`ASR_ADDR_CH4 + 8'(i), (i == 0) ? 8'h3F : 8'h7F, 1'b1);
      end
      // second reset in mid-run restores every register
      @(negedge clk_i);
      srst_i = 1'b1;
      repeat (6) @(negedge clk_i);
      srst_i = 1'b0;
      for (int i = 0; i < 3; i++) rdchk(`ASR_ADDR_CH4 + 8'(i), 8'h03 + 8'(i), 1'b1);
      conclude();
   end
endmodule
bind asr_rx_slot_map asr_rx_props chk_u (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .reg_hit_o(reg_hit_o), .out_word_o(out_word_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
   .loop_sel_o(loop_sel_o));
